// File: inc/psc_pkg.sv
// Constants, field layouts and carrier types of the palette, sprite and clock register group.
// Assumes an AXI4-Lite master with 32-bit data; each register sits in one aligned word.
// Function
// - Palette index is pixel ANDed with mask
// - Palette stores only upper six data bits
// - Data register reaches selected palette element
// - Element field picks red, green, blue, discard
// - Order bit adds discarded access after blue
// - Sprite data reaches selected sprite location
// - Prefetch registers read/write, no display use
// - Select 01, non-extended 00 give text clocks
// - Select 10/11, extended 00 clocks
// - Extended bit from external select bit7
// - Scale field: 00 passes, 01 halves
// - Prefetch index write loads, then increments
package psc_pkg;

    // ****************************************************************
    // Register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [7:0] IDX_CLK_FREQ  = 8'h54;
    localparam logic [7:0] IDX_PF_INDEX  = 8'h62;
    localparam logic [7:0] IDX_PAL_MASK  = 8'h64;
    localparam logic [7:0] IDX_PAL_DATA  = 8'h65;
    localparam logic [7:0] IDX_PAL_SEQ   = 8'h66;
    localparam logic [7:0] IDX_PF_RED    = 8'h67;
    localparam logic [7:0] IDX_PF_GREEN  = 8'h68;
    localparam logic [7:0] IDX_PF_BLUE   = 8'h69;
    localparam logic [7:0] IDX_SPR_DATA  = 8'h6a;
    localparam logic [7:0] IDX_SPR_PF    = 8'h6b;
    localparam logic [7:0] IDX_EXT_CLK   = 8'h70;

    // ****************************************************************
    // Field positions and codes
    // ****************************************************************
    localparam int unsigned SEQ_ORDER_BIT = 2;      // Colour order bit
    localparam int unsigned CFS_SEL_LSB   = 2;      // Two-bit clock select
    localparam int unsigned ECS_EXT_BIT   = 7;      // Extended clock bit
    localparam logic [1:0]  ELEM_RED      = 2'h0;
    localparam logic [1:0]  ELEM_GREEN    = 2'h1;
    localparam logic [1:0]  ELEM_BLUE     = 2'h2;
    localparam logic [1:0]  ELEM_DISC     = 2'h3;
    localparam logic [1:0]  SEL_00        = 2'h0;
    localparam logic [1:0]  SEL_01        = 2'h1;
    localparam logic [1:0]  SEL_10        = 2'h2;
    localparam logic [1:0]  SCALE_X1      = 2'h0;
    localparam logic [1:0]  SCALE_X2      = 2'h1;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // ****************************************************************
    // Values after reset
    // ****************************************************************
    localparam logic [7:0]  RST_REG8      = 8'h00;
    localparam logic [1:0]  RST_ELEM      = 2'h0;

    // Clock sources seen by the display timing controller
    typedef enum logic [2:0] {
        CLK_TEXT8,
        CLK_TEXT9,
        CLK_VEXT,
        CLK_HI1024,
        CLK_COL132
    } psc_clk_src_t;

    // Clock choice handed to the clock generator
    typedef struct packed {
        psc_clk_src_t src;
        logic         div2;
    } psc_clk_cfg_t;

    // One palette location, six bits per element
    typedef struct packed {
        logic [5:0] r;
        logic [5:0] g;
        logic [5:0] b;
    } psc_rgb_t;

endpackage

// File: logic/psc_regs.sv
// Palette mask/data/sequence, prefetch, sprite data and video clock select registers.
// Assumes pixel, sprite index and clock tick inputs synchronous to mclk; sprite buffer
// read data arrives combinationally for the presented sprite index.
`timescale 1ns/100ps
`default_nettype none
module psc_regs #(
    parameter int unsigned AW        = 10,      // AXI address width
    parameter int unsigned PAL_IDX_W = 8,       // Palette index width
    parameter int unsigned SPR_IDX_W = 14       // Sprite index width
) (
    input  wire logic                   mclk,
    input  wire logic                   rstn,
    input  wire logic                   ce,
    input  wire logic [AW-1:0]          s_axi_awaddr,
    input  wire logic [2:0]             s_axi_awprot,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [AW-1:0]          s_axi_araddr,
    input  wire logic [2:0]             s_axi_arprot,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    input  wire logic [PAL_IDX_W-1:0]   pix_val,
    input  wire logic                   pix_valid,
    output logic [PAL_IDX_W-1:0]        lookup_index,
    output psc_pkg::psc_rgb_t           pix_rgb,
    output logic                        pix_rgb_valid,
    input  wire logic [SPR_IDX_W-1:0]   spr_index,
    output logic [SPR_IDX_W-1:0]        spr_addr,
    output logic [7:0]                  spr_wdata,
    output logic                        spr_we,
    input  wire logic [7:0]             spr_rdata,
    input  wire logic                   vclk_tick,
    output psc_pkg::psc_clk_cfg_t       clk_cfg,
    output logic                        crt_tick
);
    import psc_pkg::*;

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    if (AW < 9 || AW > 32) $error("AW must cover index 0x70 and fit 32 bits");
    if (PAL_IDX_W < 1 || PAL_IDX_W > 8) $error("PAL_IDX_W must be 1 to 8");
    if (SPR_IDX_W < 1 || SPR_IDX_W > 16) $error("SPR_IDX_W must be 1 to 16");

    localparam int unsigned PAL_DEPTH = 1 << PAL_IDX_W;

    // ****************************************************************
    // Storage and control state
    // ****************************************************************
    psc_rgb_t               pal_ram [PAL_DEPTH];    // Palette locations
    logic [7:0]             mask_r;                 // Palette mask
    logic                   order_r;                // Colour order bit
    logic [1:0]             elem_r;                 // Current element
    logic [1:0]             elem_nxt;
    logic [PAL_IDX_W-1:0]   pidx_r;                 // Palette location
    logic [PAL_IDX_W-1:0]   pidx_nxt;
    logic [7:0]             pf_red_r;               // Prefetch holders
    logic [7:0]             pf_green_r;
    logic [7:0]             pf_blue_r;
    logic [7:0]             spr_pf_r;
    logic [3:0]             cfs_r;                  // Clock select, scale
    logic                   ext_r;                  // Extended clock bit
    logic                   phase_r;                // Halving phase
    logic                   bvalid_r;
    logic [1:0]             bresp_r;
    logic                   rvalid_r;
    logic [1:0]             rresp_r;
    logic [31:0]            rdata_r;
    logic [31:0]            rd_val;

    // ****************************************************************
    // Bus handshake and decode
    // ****************************************************************
    // Write needs both channels; it blocks a read that cycle so one access moves the sequence
    logic                   wr_go;
    logic                   rd_go;
    logic                   wr_lane;
    logic [AW-3:0]          wword;
    logic [AW-3:0]          rword;
    logic [7:0]             wd;
    assign wr_go         = ce && s_axi_awvalid && s_axi_wvalid && !bvalid_r;
    assign rd_go         = ce && s_axi_arvalid && !rvalid_r && !wr_go;
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign s_axi_arready = rd_go;
    assign wword         = s_axi_awaddr[AW-1:2];
    assign rword         = s_axi_araddr[AW-1:2];
    assign wr_lane       = wr_go && s_axi_wstrb[0];
    assign wd            = s_axi_wdata[7:0];

    // Word index matches a register index
    function automatic logic hit(input logic [AW-3:0] w, input logic [7:0] idx);
        return w == (AW-2)'(idx);
    endfunction

    // Any mapped register
    function automatic logic mapped(input logic [AW-3:0] w);
        return hit(w, IDX_CLK_FREQ) || hit(w, IDX_PF_INDEX) || hit(w, IDX_PAL_MASK)
            || hit(w, IDX_PAL_DATA) || hit(w, IDX_PAL_SEQ) || hit(w, IDX_PF_RED)
            || hit(w, IDX_PF_GREEN) || hit(w, IDX_PF_BLUE) || hit(w, IDX_SPR_DATA)
            || hit(w, IDX_SPR_PF) || hit(w, IDX_EXT_CLK);
    endfunction

    logic pd_wr;                                    // Palette data write
    logic pd_rd;                                    // Palette data read
    logic pfi_wr;                                   // Prefetch index write
    logic sd_wr;                                    // Sprite data write
    assign pd_wr  = wr_lane && hit(wword, IDX_PAL_DATA);
    assign pd_rd  = rd_go && hit(rword, IDX_PAL_DATA);
    assign pfi_wr = wr_lane && hit(wword, IDX_PF_INDEX);
    assign sd_wr  = wr_lane && hit(wword, IDX_SPR_DATA);

    // Write response, one cycle after the write is taken
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OKAY;
        end
        else if (ce)
        begin
            if (wr_go)
            begin
                bvalid_r <= 1'b1;
                bresp_r  <= mapped(wword) ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bready)
                bvalid_r <= 1'b0;
        end
    end

    // Read response, one cycle after the address is taken
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            rvalid_r <= 1'b0;
            rresp_r  <= RESP_OKAY;
            rdata_r  <= 32'h0000_0000;
        end
        else if (ce)
        begin
            if (rd_go)
            begin
                rvalid_r <= 1'b1;
                rresp_r  <= mapped(rword) ? RESP_OKAY : RESP_SLVERR;
                rdata_r  <= rd_val;
            end
            else if (s_axi_rready)
                rvalid_r <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp  = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp  = rresp_r;
    assign s_axi_rdata  = rdata_r;

    // ****************************************************************
    // Read multiplexer
    // ****************************************************************
    // Selected palette element, low two bits read as zero
    logic [7:0] pal_cur;
    always_comb
    begin
        case (elem_r)
            ELEM_RED:   pal_cur = {pal_ram[pidx_r].r, 2'b00};
            ELEM_GREEN: pal_cur = {pal_ram[pidx_r].g, 2'b00};
            ELEM_BLUE:  pal_cur = {pal_ram[pidx_r].b, 2'b00};
            default:    pal_cur = 8'h00;            // Discarded element
        endcase
    end

    always_comb
    begin
        rd_val = 32'h0000_0000;
        if (hit(rword, IDX_CLK_FREQ))      rd_val[3:0] = cfs_r;
        else if (hit(rword, IDX_PF_INDEX)) rd_val[PAL_IDX_W-1:0] = pidx_r;
        else if (hit(rword, IDX_PAL_MASK)) rd_val[7:0] = mask_r;
        else if (hit(rword, IDX_PAL_DATA)) rd_val[7:0] = pal_cur;
        else if (hit(rword, IDX_PAL_SEQ))  rd_val[2:0] = {order_r, elem_r};
        else if (hit(rword, IDX_PF_RED))   rd_val[7:0] = pf_red_r;
        else if (hit(rword, IDX_PF_GREEN)) rd_val[7:0] = pf_green_r;
        else if (hit(rword, IDX_PF_BLUE))  rd_val[7:0] = pf_blue_r;
        else if (hit(rword, IDX_SPR_DATA)) rd_val[7:0] = spr_rdata;
        else if (hit(rword, IDX_SPR_PF))   rd_val[7:0] = spr_pf_r;
        else if (hit(rword, IDX_EXT_CLK))  rd_val[ECS_EXT_BIT] = ext_r;
    end

    // ****************************************************************
    // Palette element sequencing
    // ****************************************************************
    always_comb
    begin
        elem_nxt = elem_r;
        pidx_nxt = pidx_r;
        if (pfi_wr)
            pidx_nxt = wd[PAL_IDX_W-1:0] + 1'b1;
        else if (wr_lane && hit(wword, IDX_PAL_SEQ))
            elem_nxt = wd[1:0];
        else if (pd_wr || pd_rd)
        begin
            case (elem_r)
                ELEM_RED:   elem_nxt = ELEM_GREEN;
                ELEM_GREEN: elem_nxt = ELEM_BLUE;
                ELEM_BLUE:
                begin
                    if (order_r)
                        elem_nxt = ELEM_DISC;
                    else
                    begin
                        elem_nxt = ELEM_RED;
                        pidx_nxt = pidx_r + 1'b1;
                    end
                end
                default:
                begin
                    elem_nxt = ELEM_RED;
                    pidx_nxt = pidx_r + 1'b1;
                end
            endcase
        end
    end

    // Sequence state and software-written control
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            elem_r  <= RST_ELEM;
            pidx_r  <= '0;
            order_r <= 1'b0;
            mask_r  <= RST_REG8;
            cfs_r   <= RST_REG8[3:0];
            ext_r   <= 1'b0;
        end
        else if (ce)
        begin
            elem_r <= elem_nxt;
            pidx_r <= pidx_nxt;
            if (wr_lane && hit(wword, IDX_PAL_SEQ))  order_r <= wd[SEQ_ORDER_BIT];
            if (wr_lane && hit(wword, IDX_PAL_MASK)) mask_r <= wd;
            if (wr_lane && hit(wword, IDX_CLK_FREQ)) cfs_r <= wd[3:0];
            if (wr_lane && hit(wword, IDX_EXT_CLK))  ext_r <= wd[ECS_EXT_BIT];
        end
    end

    // Palette storage; no reset, software loads every location
    always_ff @(posedge mclk)
    begin
        if (ce && pd_wr)
        begin
            case (elem_r)
                ELEM_RED:   pal_ram[pidx_r].r <= wd[7:2];
                ELEM_GREEN: pal_ram[pidx_r].g <= wd[7:2];
                ELEM_BLUE:  pal_ram[pidx_r].b <= wd[7:2];
                default:    ;                       // Discarded write
            endcase
        end
    end

    // ****************************************************************
    // Prefetch holding registers
    // ****************************************************************
    logic [PAL_IDX_W-1:0] pf_loc;
    assign pf_loc = wd[PAL_IDX_W-1:0];
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            pf_red_r   <= RST_REG8;
            pf_green_r <= RST_REG8;
            pf_blue_r  <= RST_REG8;
            spr_pf_r   <= RST_REG8;
        end
        else if (ce)
        begin
            if (pfi_wr)
            begin
                pf_red_r   <= {pal_ram[pf_loc].r, 2'b00};
                pf_green_r <= {pal_ram[pf_loc].g, 2'b00};
                pf_blue_r  <= {pal_ram[pf_loc].b, 2'b00};
            end
            if (wr_lane && hit(wword, IDX_PF_RED))   pf_red_r <= wd;
            if (wr_lane && hit(wword, IDX_PF_GREEN)) pf_green_r <= wd;
            if (wr_lane && hit(wword, IDX_PF_BLUE))  pf_blue_r <= wd;
            if (wr_lane && hit(wword, IDX_SPR_PF))   spr_pf_r <= wd;
        end
    end

    // ****************************************************************
    // Sprite buffer write port
    // ****************************************************************
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            spr_we    <= 1'b0;
            spr_wdata <= RST_REG8;
            spr_addr  <= '0;
        end
        else if (ce)
        begin
            spr_we <= sd_wr;
            if (sd_wr)
            begin
                spr_wdata <= wd;
                spr_addr  <= spr_index;
            end
        end
    end

    // ****************************************************************
    // Pixel lookup path
    // ****************************************************************
    logic [PAL_IDX_W-1:0] look_c;
    assign look_c = pix_val & mask_r[PAL_IDX_W-1:0];
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            lookup_index  <= '0;
            pix_rgb       <= '0;
            pix_rgb_valid <= 1'b0;
        end
        else if (ce)
        begin
            lookup_index  <= look_c;
            pix_rgb       <= pal_ram[look_c];
            pix_rgb_valid <= pix_valid;
        end
    end

    // ****************************************************************
    // Video clock selection and scaling
    // ****************************************************************
    always_comb
    begin
        clk_cfg.div2 = (cfs_r[1:0] == SCALE_X2);
        case (cfs_r[CFS_SEL_LSB +: 2])
            SEL_00:  clk_cfg.src = ext_r ? CLK_COL132 : CLK_TEXT8;
            SEL_01:  clk_cfg.src = CLK_TEXT9;
            SEL_10:  clk_cfg.src = CLK_VEXT;
            default: clk_cfg.src = CLK_HI1024;
        endcase
    end

    // Reserved scale codes pass the clock unchanged rather than stop it
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            phase_r  <= 1'b0;
            crt_tick <= 1'b0;
        end
        else if (ce)
        begin
            crt_tick <= vclk_tick && (!clk_cfg.div2 || phase_r);
            if (vclk_tick) phase_r <= clk_cfg.div2 ? !phase_r : 1'b0;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    sequence s_blue_access;
        ce && (pd_wr || pd_rd) && elem_r == ELEM_BLUE;
    endsequence

    property p_mask_index;
        ce |=> lookup_index == $past(pix_val & mask_r[PAL_IDX_W-1:0]);
    endproperty
    a_mask_index: assert property (p_mask_index) else $error("lookup index not masked");

    property p_six_bits;
        ce && pd_wr && elem_r == ELEM_GREEN |=> pal_ram[$past(pidx_r)].g == $past(wd[7:2]);
    endproperty
    a_six_bits: assert property (p_six_bits) else $error("palette store wrong");

    property p_read_elem;
        ce && pd_rd |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(pal_cur);
    endproperty
    a_read_elem: assert property (p_read_elem) else $error("palette read wrong");

    property p_disc_read;
        ce && pd_rd && elem_r == ELEM_DISC |=> s_axi_rdata[1:0] == 2'b00 && elem_r == ELEM_RED;
    endproperty
    a_disc_read: assert property (p_disc_read) else $error("discard read wrong");

    property p_order_rgb;
        s_blue_access ##0 !order_r |=> elem_r == ELEM_RED && pidx_r == $past(pidx_r) + 1'b1;
    endproperty
    a_order_rgb: assert property (p_order_rgb) else $error("rgb order wrong");

    property p_order_x;
        s_blue_access ##0 order_r |=> elem_r == ELEM_DISC && pidx_r == $past(pidx_r);
    endproperty
    a_order_x: assert property (p_order_x) else $error("discard step missing");

    property p_spr_write;
        ce && sd_wr |=> spr_we && spr_wdata == $past(wd) && spr_addr == $past(spr_index);
    endproperty
    a_spr_write: assert property (p_spr_write) else $error("sprite write lost");

    sequence s_pf_write;
        ce && wr_lane && hit(wword, IDX_PF_GREEN) && !pfi_wr;
    endsequence
    property p_pf_keep;
        s_pf_write |=> pf_green_r == $past(wd);
    endproperty
    a_pf_keep: assert property (p_pf_keep) else $error("prefetch not stored");

    property p_clk_src;
        cfs_r[CFS_SEL_LSB +: 2] == SEL_00 |-> clk_cfg.src == (ext_r ? CLK_COL132 : CLK_TEXT8);
    endproperty
    a_clk_src: assert property (p_clk_src) else $error("clock source wrong");

    property p_halve;
        ce && clk_cfg.div2 && crt_tick |-> !phase_r;
    endproperty
    a_halve: assert property (p_halve) else $error("halving phase wrong");

    property p_pf_index;
        ce && pfi_wr |=> pidx_r == $past(pf_loc) + 1'b1
                         && pf_red_r[7:2] == pal_ram[$past(pf_loc)].r;
    endproperty
    a_pf_index: assert property (p_pf_index) else $error("prefetch load wrong");

endmodule
`default_nettype wire

// File: verif/psc_regs_tb.sv
// Self-checking bench of the palette, sprite and video clock register group.
// Assumes psc_pkg is compiled first; the bench is the AXI4-Lite master.
`timescale 1ns/100ps
`default_nettype none
module psc_regs_tb;
import psc_pkg::*;
logic mclk = 0, rstn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, ce = 1;
logic vclk = 0, pix_valid = 0, awrdy, wrdy, bvalid, arrdy, rvalid, prv, spr_we, crt_tick;
logic [9:0] awaddr = 0, araddr = 0;
logic [31:0] wdata = 0, rdata, q;
logic [1:0] bresp, rresp, r;
logic [7:0] pix_val = 0, spr_rdata = 0, lookup_index, spr_wdata, sd, d, m, l;
logic [13:0] spr_index = 0, spr_addr, sa, s_a;
logic [7:0] c [3];
logic [7:0] ix [5] = '{IDX_PF_RED, IDX_PF_GREEN, IDX_PF_BLUE, IDX_SPR_PF, IDX_PAL_MASK};
psc_rgb_t pix_rgb;
psc_clk_cfg_t clk_cfg;
int seed = 21079, miscompares = 0, n_checks = 0, cyc = 0, n_crt = 0;
psc_regs DUT (.mclk(mclk), .rstn(rstn), .ce(ce), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awrdy), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arrdy), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pix_val(pix_val),
    .pix_valid(pix_valid), .lookup_index(lookup_index), .pix_rgb(pix_rgb),
    .pix_rgb_valid(prv), .spr_index(spr_index), .spr_addr(spr_addr), .spr_wdata(spr_wdata),
    .spr_we(spr_we), .spr_rdata(spr_rdata), .vclk_tick(vclk), .clk_cfg(clk_cfg),
    .crt_tick(crt_tick));
// 50 MHz clock
always #10 mclk = ~mclk;
// Hang guard and sprite/tick monitors
always @(posedge mclk)
begin
    cyc++;
    if (crt_tick === 1'b1) n_crt <= n_crt + 1;
    if (spr_we === 1'b1) {s_a, sd} <= {spr_addr, spr_wdata};
    if (cyc == 8000) begin miscompares++; give_verdict; end
end
task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
        $display("Result: passed");
    else
        $display("Result: failed");
    $finish;
endtask
task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin miscompares++; $display("[ERR] %s exp %h got %h", nm, e, g); end
endtask
// Write: both channels offered together, held until taken
task wr(input logic [7:0] i, input logic [7:0] v);
    @(posedge mclk);
    {awaddr, wdata, awv, wv, bready} <= {i, 2'h0, 24'h0, v, 3'h7};
    do @(negedge mclk); while (awrdy !== 1'b1);
    @(posedge mclk);
    {awv, wv} <= 2'h0;
    do @(negedge mclk); while (bvalid !== 1'b1);
    r = bresp;
    @(posedge mclk);
    bready <= 0;
endtask
task rd(input logic [7:0] i);
    @(posedge mclk);
    {araddr, arv, rready} <= {i, 2'h0, 2'h3};
    do @(negedge mclk); while (arrdy !== 1'b1);
    @(posedge mclk);
    arv <= 0;
    do @(negedge mclk); while (rvalid !== 1'b1);
    {q, r} = {rdata, rresp};
    @(posedge mclk);
    rready <= 0;
endtask
// Expected clock choice from extended bit, select and scale
function automatic logic [3:0] exp_cfg(input logic e, input logic [1:0] s, input logic v);
    psc_clk_src_t t;
    t = (s == 2'h1) ? CLK_TEXT9 : (s == 2'h2) ? CLK_VEXT : (s == 2'h3) ? CLK_HI1024 :
        e ? CLK_COL132 : CLK_TEXT8;
    return {t, v};
endfunction
task pix(input logic [7:0] p);
    pix_val <= p;
    pix_valid <= 1;
    @(posedge mclk);
    @(negedge mclk);
endtask
initial
begin
    repeat (5) @(posedge mclk);
    rstn <= 1;
    // Load every location from index 0 so no lookup or prefetch sees an unset entry
    for (int i = 0; i < 768; i++)
        wr(IDX_PAL_DATA, (i % 3 == 1) ? 8'($random(seed)) : 8'h00);
    foreach (ix[k]) begin d = 8'($random(seed)); wr(ix[k], d); rd(ix[k]);
        chk("rw", {24'h0, d}, q); end
    wr(8'h71, 8'h5a);
    chk("bresp", RESP_SLVERR, r);
    rd(8'h71);
    chk("rresp", {RESP_SLVERR, 8'h0}, {r, q[7:0]});
    repeat (6) begin {m, d} = 16'($random(seed)); wr(IDX_PAL_MASK, m); pix(d);
        chk("lookup", d & m, lookup_index);
        chk("mono", 12'h0, {pix_rgb.r, pix_rgb.b}); end
    for (int o = 0; o < 2; o++)
    begin
        l = 8'($random(seed));
        wr(IDX_PAL_SEQ, {5'h0, o[0], 2'h0});
        wr(IDX_PF_INDEX, l - 8'h1);
        for (int k = 0; k < 3; k++) begin c[k] = 8'($random(seed)); wr(IDX_PAL_DATA, c[k]); end
        rd(IDX_PAL_SEQ);
        chk("seq", o ? 7 : 0, q);
        if (o)
        begin
            rd(IDX_PAL_DATA);
            chk("disc", 32'h0, q);
            wr(IDX_PAL_SEQ, 8'h07);
            wr(IDX_PAL_DATA, 8'hff);
        end
        rd(IDX_PF_INDEX);
        chk("index", {24'h0, l + 8'h1 + 8'(o)}, q);
        wr(IDX_PAL_MASK, 8'hff);
        pix(l);
        chk("rgb", {prv, c[0][7:2], c[1][7:2], c[2][7:2]}, {prv, pix_rgb});
        wr(IDX_PF_INDEX, l);
        for (int k = 0; k < 3; k++) begin rd(ix[k]); chk("pf", {c[k][7:2], 2'h0}, q);
            c[k] = q[7:0]; end
        wr(IDX_PF_INDEX, l - 8'h1);
        wr(IDX_PAL_SEQ, {5'h0, o[0], 2'h1});
        rd(IDX_PAL_DATA);
        chk("pdrd", {c[1][7:2], 2'h0}, q);
    end
    // Put back the prefetch values saved from location l in the last pass, after its palette writes
    foreach (c[k]) begin wr(ix[k], c[k]); rd(ix[k]); chk("restore", c[k], q); end
    repeat (4) begin {sa, d} = 22'($random(seed)); spr_index <= sa; spr_rdata <= ~d;
        wr(IDX_SPR_DATA, d); @(negedge mclk); chk("spr", {sa, d}, {s_a, sd});
        rd(IDX_SPR_DATA); chk("sprrd", {24'h0, ~d}, q); end
    for (int k = 0; k < 16; k++)
    begin
        wr(IDX_EXT_CLK, {k[3], 7'h0});
        wr(IDX_CLK_FREQ, {4'h0, k[2:1], 1'b0, k[0]});
        @(negedge mclk);
        chk("cfg", exp_cfg(k[3], k[2:1], k[0]), clk_cfg);
        n_crt = 0;
        repeat (4) begin @(posedge mclk); vclk <= 1; @(posedge mclk); vclk <= 0; end
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        chk("ticks", k[0] ? 2 : 4, n_crt);
    end
    // Ticks offered while the enable is low must not reach the controller
    n_crt = 0;
    ce <= 0;
    vclk <= 1;
    repeat (3) @(posedge mclk);
    {ce, vclk} <= 2'b10;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk("frozen", 0, n_crt);
    give_verdict;
end
endmodule
`default_nettype wire
